/* fenc_pkg.sv */
// package: symbol codes, word layouts and carrier structs for the flow-credit / n-char codec
package fenc_pkg;

  // ----------------------------------------
  // symbol values (byte value of the 8b/10b symbol, k flag alongside)
  // ----------------------------------------
  localparam logic [7:0] FENC_K28_3      = 8'h7c;
  localparam logic [7:0] FENC_K0_0       = 8'h00;
  localparam logic [7:0] FENC_D0_0       = 8'h00;
  localparam logic [7:0] FENC_K29_7      = 8'hfd;
  localparam logic [7:0] FENC_K30_7      = 8'hfe;

  // ----------------------------------------
  // word layout: lane 0 is least significant and sent first
  // ----------------------------------------
  localparam int FENC_LANES       = 4;
  localparam int FENC_LANE_KCODE  = 0;
  localparam int FENC_LANE_VC     = 1;
  localparam int FENC_LANE_SEQ    = 2;
  localparam int FENC_LANE_CRC    = 3;
  localparam int FENC_VC_W        = 8;
  localparam int FENC_SEQ_CNT_W   = 7;
  localparam int FENC_SEQ_POL_BIT = 7;
  localparam int FENC_NUM_VC      = 8;

  // ----------------------------------------
  // crc-8 over the first three symbols of a flow-credit word
  // ----------------------------------------
  localparam logic [7:0] FENC_CRC_POLY  = 8'h07;
  localparam logic [7:0] FENC_CRC_INIT  = 8'h00;
  localparam logic [7:0] FENC_SEQ_RESET = 8'h00;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    FENC_NC_DATA,
    FENC_NC_NORMAL_END,
    FENC_NC_ERROR_END,
    FENC_NC_NONE
  } fenc_nchar_kind_t;

  typedef struct packed {
    fenc_nchar_kind_t kind;
    logic [7:0]       data;
  } fenc_nchar_t;

  typedef struct packed {
    logic [3:0]  k;
    logic [31:0] sym;
  } fenc_word_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] vc;
    logic [7:0] seq;
  } fenc_credit_t;

endpackage : fenc_pkg

/* fenc_crc8.sv */
// combinational crc-8 over three symbols of a flow-credit word
module fenc_crc8 (
  input  wire logic [23:0] data,
  output logic      [7:0]  crc
);

  // ----------------------------------------
  // bitwise crc, symbol 0 first, lsb first to match send order
  // ----------------------------------------
  always_comb begin
    logic [7:0] c;
    logic       fb;
    c  = fenc_pkg::FENC_CRC_INIT;
    fb = 1'b0;
    for (int i = 0; i < 24; i++) begin
      fb = c[7] ^ data[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ fenc_pkg::FENC_CRC_POLY;
      end
    end
    crc = c;
  end

endmodule : fenc_crc8

/* fenc_seq.sv */
// frame sequence number: polarity flag plus modulo-128 count shared by all framed sends
module fenc_seq (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       flush,
  input  wire logic       retry_start,
  input  wire logic       advance,
  output logic      [7:0] seq_reg
);

  // ----------------------------------------
  // one counter for data, broadcast and flow-credit sends
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      seq_reg <= fenc_pkg::FENC_SEQ_RESET;
    end else begin
      if (advance) begin
        seq_reg[fenc_pkg::FENC_SEQ_CNT_W-1:0] <=
          seq_reg[fenc_pkg::FENC_SEQ_CNT_W-1:0] + 7'h01;
      end
      if (retry_start) begin
        seq_reg[fenc_pkg::FENC_SEQ_POL_BIT] <= ~seq_reg[fenc_pkg::FENC_SEQ_POL_BIT];
      end
    end
  end

endmodule : fenc_seq

/* fenc_codec.sv */
// top: flow-credit word and n-char symbol codec, transmit and receive
module fenc_codec (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // transmit side, from the upper layer
  input  wire logic                  flush,
  input  wire logic                  retry_start,
  input  wire logic                  frame_sent,
  input  wire logic                  credit_req,
  input  wire logic [7:0]            credit_vc,
  input  wire logic [7:0]            buffer_room,
  input  wire fenc_pkg::fenc_nchar_t [3:0] tx_nchar,
  input  wire logic                  tx_nchar_valid,
  output fenc_pkg::fenc_word_t       tx_word_reg,
  output logic                       tx_word_valid_reg,
  output logic                       credit_taken_reg,
  output logic [7:0]                 tx_seq_reg,
  // receive side, from the lane decoder
  input  wire fenc_pkg::fenc_word_t  rx_word,
  input  wire logic                  rx_word_valid,
  input  wire logic [3:0]            rx_sym_err,
  input  wire logic                  rx_sync_ready,
  input  wire logic                  signal_loss,
  output fenc_pkg::fenc_word_t       rx_up_word_reg,
  output logic                       rx_up_valid_reg,
  output fenc_pkg::fenc_nchar_t [3:0] rx_nchar_reg,
  output logic                       rx_nchar_valid_reg,
  output logic [3:0]                 rx_packet_start_reg,
  output fenc_pkg::fenc_credit_t     rx_credit_reg,
  output logic                       rx_crc_err_reg,
  output logic                       rx_seq_err_reg
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // decode of one received symbol, used for every lane
  function automatic fenc_pkg::fenc_nchar_t fenc_decode(input logic k, input logic [7:0] s);
    fenc_pkg::fenc_nchar_t n;
    n.data = s;
    if (!k) begin
      n.kind = fenc_pkg::FENC_NC_DATA;
    end else if (s == fenc_pkg::FENC_K29_7) begin
      n.kind = fenc_pkg::FENC_NC_NORMAL_END;
    end else if (s == fenc_pkg::FENC_K30_7) begin
      n.kind = fenc_pkg::FENC_NC_ERROR_END;
    end else begin
      n.kind = fenc_pkg::FENC_NC_NONE;
    end
    return n;
  endfunction : fenc_decode

  function automatic fenc_pkg::fenc_word_t fenc_err_word();
    fenc_pkg::fenc_word_t w;
    w.k   = 4'h1;
    w.sym = {fenc_pkg::FENC_D0_0, fenc_pkg::FENC_D0_0, fenc_pkg::FENC_D0_0,
             fenc_pkg::FENC_K0_0};
    return w;
  endfunction : fenc_err_word

  // ----------------------------------------
  // transmit: sequence counter and flow-credit word
  // ----------------------------------------
  logic [7:0] seq_now;
  logic       credit_go;
  logic [7:0] tx_crc;

  // a credit waits for the room flag of its channel; vc above range never goes
  // nor does one beside a sent frame: the shared count moves one step per cycle
  assign credit_go = credit_req && !frame_sent &&
                     (credit_vc < 8'(fenc_pkg::FENC_NUM_VC)) &&
                     buffer_room[credit_vc[2:0]];

  fenc_seq u_seq (
    .core_clk    (core_clk),
    .reset       (reset),
    .flush       (flush),
    .retry_start (retry_start),
    .advance     (frame_sent || credit_go),
    .seq_reg     (seq_now)
  );

  fenc_crc8 u_tx_crc (
    .data (
      {seq_now, credit_vc, fenc_pkg::FENC_K28_3}),
    .crc  (tx_crc)
  );

  // strobes apart from the word: they clear every cycle, the word keeps its last value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_word_valid_reg <= 1'b0;
      credit_taken_reg  <= 1'b0;
    end else begin
      tx_word_valid_reg <= credit_go || tx_nchar_valid;
      credit_taken_reg  <= credit_go;
    end
  end

  // credit has priority over n-chars in the same cycle; n-chars are then dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_word_reg <= '0;
    end else begin
      if (credit_go) begin
        tx_word_reg.k   <= 4'h1;
        tx_word_reg.sym <= {tx_crc, seq_now, credit_vc, fenc_pkg::FENC_K28_3};
      end else if (tx_nchar_valid) begin
        for (int i = 0; i < fenc_pkg::FENC_LANES; i++) begin
          // no path builds K0.0, so an error word can never leave here
          unique case (tx_nchar[i].kind)
            fenc_pkg::FENC_NC_DATA: begin
              tx_word_reg.k[i]           <= 1'b0;
              tx_word_reg.sym[i*8 +: 8]  <= tx_nchar[i].data;
            end
            fenc_pkg::FENC_NC_NORMAL_END: begin
              tx_word_reg.k[i]           <= 1'b1;
              tx_word_reg.sym[i*8 +: 8]  <= fenc_pkg::FENC_K29_7;
            end
            fenc_pkg::FENC_NC_ERROR_END: begin
              tx_word_reg.k[i]           <= 1'b1;
              tx_word_reg.sym[i*8 +: 8]  <= fenc_pkg::FENC_K30_7;
            end
            fenc_pkg::FENC_NC_NONE: begin
              tx_word_reg.k[i]           <= 1'b0;
              tx_word_reg.sym[i*8 +: 8]  <= fenc_pkg::FENC_D0_0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_seq_reg <= fenc_pkg::FENC_SEQ_RESET;
    end else begin
      tx_seq_reg <= seq_now;
    end
  end

  // ----------------------------------------
  // receive: error substitution
  // ----------------------------------------
  logic       rx_bad;
  logic       rx_block;
  logic       rx_is_credit;
  logic [7:0] rx_crc;
  logic       rx_clean;

  assign rx_block = signal_loss || !rx_sync_ready;
  assign rx_bad   = rx_word_valid && (|rx_sym_err);
  assign rx_clean = rx_word_valid && !rx_block && !rx_bad;
  assign rx_is_credit = rx_word.k == 4'h1 &&
                        rx_word.sym[7:0] == fenc_pkg::FENC_K28_3;

  fenc_crc8 u_rx_crc (
    .data (rx_word.sym[23:0]),
    .crc  (rx_crc)
  );

  // while blocked an error word goes up every cycle, so loss always yields at least one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_up_word_reg  <= '0;
      rx_up_valid_reg <= 1'b0;
    end else begin
      rx_up_valid_reg <= rx_block || rx_word_valid;
      if (rx_block || rx_bad) begin
        rx_up_word_reg <= fenc_err_word();
      end else begin
        rx_up_word_reg <= rx_word;
      end
    end
  end

  // ----------------------------------------
  // receive: n-char decode
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_nchar_reg       <= '0;
      rx_nchar_valid_reg <= 1'b0;
    end else begin
      rx_nchar_valid_reg <= rx_clean && !rx_is_credit;
      for (int i = 0; i < fenc_pkg::FENC_LANES; i++) begin
        rx_nchar_reg[i] <= fenc_decode(rx_word.k[i], rx_word.sym[i*8 +: 8]);
      end
    end
  end

  // lane i opens a packet when it is data and the nearest lane before it that is not an unknown k-code closed one
  logic       prev_end_reg;
  logic [3:0] start_next;
  logic [4:0] end_chain;

  always_comb begin
    fenc_pkg::fenc_nchar_t n;
    n          = '0;
    end_chain  = '0;
    start_next = '0;
    end_chain[0] = prev_end_reg;
    for (int i = 0; i < fenc_pkg::FENC_LANES; i++) begin
      n = fenc_decode(rx_word.k[i], rx_word.sym[i*8 +: 8]);
      start_next[i] = end_chain[i] && n.kind == fenc_pkg::FENC_NC_DATA;
      if (n.kind == fenc_pkg::FENC_NC_DATA) begin
        end_chain[i+1] = 1'b0;
      end else if (n.kind == fenc_pkg::FENC_NC_NONE) begin
        end_chain[i+1] = end_chain[i];
      end else begin
        end_chain[i+1] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_end_reg        <= 1'b1;
      rx_packet_start_reg <= '0;
    end else if (rx_clean && !rx_is_credit) begin
      prev_end_reg        <= end_chain[fenc_pkg::FENC_LANES];
      rx_packet_start_reg <= start_next;
    end else begin
      rx_packet_start_reg <= '0;
    end
  end

  // ----------------------------------------
  // receive: flow-credit check
  // ----------------------------------------
  logic [6:0] rx_expect_reg;
  logic       rx_good_credit;
  logic       rx_crc_fail;
  logic       rx_crc_ok;

  // a credit with a bad crc grants nothing; the retry layer sees the flag instead
  assign rx_crc_ok      = rx_crc == rx_word.sym[31:24];
  assign rx_good_credit = rx_clean && rx_is_credit && rx_crc_ok;
  assign rx_crc_fail    = rx_clean && rx_is_credit && !rx_crc_ok;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_credit_reg <= '0;
    end else begin
      rx_credit_reg.valid <= rx_good_credit;
      rx_credit_reg.vc    <= rx_word.sym[15:8];
      rx_credit_reg.seq   <= rx_word.sym[23:16];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_crc_err_reg <= 1'b0;
    end else begin
      rx_crc_err_reg <= rx_crc_fail;
    end
  end

  // ----------------------------------------
  // receive: sequence check
  // ----------------------------------------
  // the count expected next; the upper layer resyncs on flush
  always_ff @(posedge core_clk) begin
    if (reset || flush) begin
      rx_expect_reg  <= '0;
      rx_seq_err_reg <= 1'b0;
    end else begin
      rx_seq_err_reg <= rx_good_credit &&
                        rx_word.sym[22:16] != rx_expect_reg;
      if (rx_good_credit) begin
        rx_expect_reg <= rx_word.sym[22:16] + 7'h01;
      end
    end
  end

endmodule : fenc_codec

/* fenc_codec_properties.sv */
// checker: concurrent properties on the ports of the codec top
module fenc_codec_properties (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic                        frame_sent,
  input wire logic                        flush,
  input wire logic                        retry_start,
  input wire logic                        credit_req,
  input wire logic [7:0]                  credit_vc,
  input wire logic [7:0]                  buffer_room,
  input wire fenc_pkg::fenc_nchar_t [3:0] tx_nchar,
  input wire logic                        tx_nchar_valid,
  input wire fenc_pkg::fenc_word_t        tx_word_reg,
  input wire logic                        tx_word_valid_reg,
  input wire logic                        credit_taken_reg,
  input wire logic [7:0]                  tx_seq_reg,
  input wire logic                        rx_word_valid,
  input wire logic [3:0]                  rx_sym_err,
  input wire logic                        rx_sync_ready,
  input wire logic                        signal_loss,
  input wire fenc_pkg::fenc_word_t        rx_up_word_reg,
  input wire logic                        rx_up_valid_reg,
  input wire logic                        rx_nchar_valid_reg,
  input wire fenc_pkg::fenc_credit_t      rx_credit_reg,
  input wire logic                        rx_crc_err_reg
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  localparam logic [35:0] ERR_W = 36'h100000000;
  logic room;
  assign room = credit_req && !frame_sent && (credit_vc < 8'h08) && buffer_room[credit_vc[2:0]];

  chk_credit_build: assert property (room |=> tx_word_valid_reg && credit_taken_reg
    && tx_word_reg.k == 4'h1 && tx_word_reg.sym[15:0] == {$past(credit_vc), fenc_pkg::FENC_K28_3})
    else $error("credit word malformed");
  chk_credit_room: assert property (credit_taken_reg |-> $past(room))
    else $error("credit sent without room");
  chk_credit_seq: assert property (credit_taken_reg |-> tx_word_reg.sym[23:16] == tx_seq_reg)
    else $error("credit sequence byte wrong");
  chk_retry_flip: assert property (retry_start && !flush |=> ##1
    tx_seq_reg[7] != $past(tx_seq_reg[7])) else $error("polarity did not flip");
  chk_rx_symerr: assert property (rx_word_valid && |rx_sym_err |=> rx_up_valid_reg
    && rx_up_word_reg == ERR_W && !rx_nchar_valid_reg) else $error("bad word not replaced");
  chk_sync_err: assert property (!rx_sync_ready |=> rx_up_valid_reg && rx_up_word_reg == ERR_W)
    else $error("stream passed while not ready");
  chk_loss_block: assert property (signal_loss |=> rx_up_valid_reg && rx_up_word_reg == ERR_W
    && !rx_nchar_valid_reg && !rx_credit_reg.valid) else $error("words passed during loss");
  chk_no_tx_err: assert property (tx_word_valid_reg |-> tx_word_reg != ERR_W)
    else $error("error word transmitted");
  chk_data_map: assert property (tx_nchar_valid && !credit_req
    && tx_nchar[0].kind == fenc_pkg::FENC_NC_DATA |=> tx_word_valid_reg && !tx_word_reg.k[0]
    && tx_word_reg.sym[7:0] == $past(tx_nchar[0].data)) else $error("data byte mapped wrong");
  chk_end_codes: assert property (tx_nchar_valid && !credit_req
    && tx_nchar[3].kind inside {fenc_pkg::FENC_NC_NORMAL_END, fenc_pkg::FENC_NC_ERROR_END}
    |=> tx_word_reg.k[3] && tx_word_reg.sym[31:24] == ($past(tx_nchar[3].kind)
    == fenc_pkg::FENC_NC_NORMAL_END ? fenc_pkg::FENC_K29_7 : fenc_pkg::FENC_K30_7))
    else $error("packet end code wrong");
  chk_crc_bad: assert property (rx_crc_err_reg |-> !rx_credit_reg.valid)
    else $error("credit granted despite crc error");
  cover property (credit_taken_reg);
  cover property (rx_crc_err_reg);
  cover property (signal_loss ##1 rx_up_valid_reg);
endmodule : fenc_codec_properties

/* fenc_lane_model.sv */
// lane model: loops transmitted words back as received words, with commanded faults
module fenc_lane_model (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire fenc_pkg::fenc_word_t tx_word,
  input  wire logic                 tx_valid,
  input  wire logic [3:0]           inj_err,
  input  wire logic                 bad_crc,
  output fenc_pkg::fenc_word_t      rx_word,
  output logic                      rx_valid,
  output logic [3:0]                rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    rx_valid <= !reset && tx_valid;
    rx_err   <= tx_valid ? inj_err : 4'h0;
    // idle cycles show the inverse so a stale word never looks fresh
    rx_word  <= reset ? '0 : tx_valid ? tx_word ^ {4'h0, bad_crc, 31'h0} : ~rx_word;
  end
endmodule : fenc_lane_model

/* fenc_codec_tb_top.sv */
// testbench: random and corner stimulus for the codec through a loop-back lane model
module fenc_codec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, flush, retry_start, frame_sent, credit_req, tx_nchar_valid, bad_crc;
  logic rx_word_valid, rx_sync_ready, signal_loss, tx_word_valid_reg, credit_taken_reg;
  logic rx_up_valid_reg, rx_nchar_valid_reg, rx_crc_err_reg, rx_seq_err_reg, have_last, prev_end;
  logic [7:0] credit_vc, buffer_room, tx_seq_reg, exp_seq;
  logic [3:0] rx_sym_err, inj_err, rx_packet_start_reg;
  logic [6:0] last_cnt;
  logic [15:0] lfsr_state;
  fenc_pkg::fenc_nchar_t [3:0] tx_nchar, rx_nchar_reg;
  fenc_pkg::fenc_word_t tx_word_reg, rx_word, rx_up_word_reg;
  fenc_pkg::fenc_credit_t rx_credit_reg;
  int mismatches, total_checks;

  fenc_codec dut (.*);
  fenc_lane_model u_lane (.core_clk(core_clk), .reset(reset), .tx_word(tx_word_reg),
    .tx_valid(tx_word_valid_reg), .inj_err(inj_err), .bad_crc(bad_crc), .rx_word(rx_word),
    .rx_valid(rx_word_valid), .rx_err(rx_sym_err));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state[7:0];
  endfunction : rnd
  function automatic logic [8:0] enc(fenc_pkg::fenc_nchar_t n);
    case (n.kind)
      fenc_pkg::FENC_NC_DATA:       return {1'b0, n.data};
      fenc_pkg::FENC_NC_NORMAL_END: return {1'b1, fenc_pkg::FENC_K29_7};
      fenc_pkg::FENC_NC_ERROR_END:  return {1'b1, fenc_pkg::FENC_K30_7};
      default:                      return {1'b0, fenc_pkg::FENC_D0_0};
    endcase
  endfunction : enc
  function automatic logic [7:0] crc8(logic [23:0] d);
    logic [7:0] c;
    c = fenc_pkg::FENC_CRC_INIT;
    for (int i = 0; i < 24; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? fenc_pkg::FENC_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic cmp_word(string what, logic [35:0] e, logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_word
  task automatic cmp_val(string what, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_val
  task automatic send_credit(logic [7:0] vc, logic [7:0] room, logic crcbad);
    logic take;
    logic [35:0] ew;
    take = (vc < 8'h08) && room[vc[2:0]];
    credit_req = 1'b1;
    credit_vc = vc;
    buffer_room = room;
    bad_crc = crcbad;
    step();
    credit_req = 1'b0;
    cmp_val("taken", {7'h0, take}, {7'h0, credit_taken_reg});
    ew = {4'h1, crc8({exp_seq, vc, fenc_pkg::FENC_K28_3}), exp_seq, vc, fenc_pkg::FENC_K28_3};
    if (take) cmp_word("credit", ew, tx_word_reg);
    step();
    step();
    bad_crc = 1'b0;
    if (take) begin
      cmp_val("credit ok", {7'h0, !crcbad}, {7'h0, rx_credit_reg.valid});
      cmp_val("crc flag", {7'h0, crcbad}, {7'h0, rx_crc_err_reg});
      if (!crcbad) begin
        cmp_val("credit vc", vc, rx_credit_reg.vc);
        cmp_val("credit seq", exp_seq, rx_credit_reg.seq);
        if (have_last) cmp_val("seq err", {7'h0, exp_seq[6:0] != last_cnt + 7'h1}, {7'h0, rx_seq_err_reg});
        last_cnt = exp_seq[6:0];
        have_last = 1'b1;
      end
      exp_seq[6:0] = exp_seq[6:0] + 7'h1;
    end
  endtask : send_credit
  task automatic frames(int n);
    frame_sent = 1'b1;
    repeat (n) step();
    frame_sent = 1'b0;
    exp_seq[6:0] = exp_seq[6:0] + n[6:0];
  endtask : frames
  task automatic send_nchars(logic [3:0] err);
    fenc_pkg::fenc_nchar_t [3:0] n;
    logic [35:0] ew;
    logic [3:0] st;
    logic [8:0] e;
    for (int i = 0; i < 4; i++) begin
      n[i].kind = fenc_pkg::fenc_nchar_kind_t'(rnd() & 8'h03);
      n[i].data = rnd();
      e = enc(n[i]);
      ew[32 + i] = e[8];
      ew[8 * i +: 8] = e[7:0];
      st[i] = !e[8] && prev_end;
      prev_end = e[8];
    end
    tx_nchar = n;
    tx_nchar_valid = 1'b1;
    inj_err = err;
    step();
    tx_nchar_valid = 1'b0;
    cmp_word("nchar word", ew, tx_word_reg);
    step();
    step();
    inj_err = 4'h0;
    if (err != 4'h0) cmp_word("error word", 36'h100000000, rx_up_word_reg);
    cmp_val("nchar valid", {7'h0, err == 4'h0}, {7'h0, rx_nchar_valid_reg});
    if (err == 4'h0) begin
      cmp_word("rx word", ew, rx_up_word_reg);
      for (int i = 0; i < 4; i++) cmp_val("rx kind", ew[32 + i] ? n[i].kind : 8'h0, rx_nchar_reg[i].kind);
      for (int i = 0; i < 4; i++) if (!ew[32 + i]) cmp_val("rx data", ew[8 * i +: 8], rx_nchar_reg[i].data);
      cmp_val("start", {4'h0, st}, {4'h0, rx_packet_start_reg});
    end
  endtask : send_nchars
  task automatic bad_window(logic loss);
    signal_loss = loss;
    rx_sync_ready = loss;
    credit_req = 1'b1;
    credit_vc = 8'h00;
    buffer_room = 8'hff;
    for (int c = 0; c < 5; c++) begin
      step();
      cmp_word("held error", 36'h100000000, rx_up_word_reg);
      if (loss) cmp_val("loss quiet", 8'h0, {6'h0, rx_nchar_valid_reg, rx_credit_reg.valid});
    end
    credit_req = 1'b0;
    signal_loss = 1'b0;
    rx_sync_ready = 1'b1;
    exp_seq[6:0] = exp_seq[6:0] + 7'h5;
    have_last = 1'b0;
    repeat (3) step();
  endtask : bad_window
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {flush, retry_start, frame_sent, credit_req, tx_nchar_valid, bad_crc, signal_loss} = '0;
    {credit_vc, buffer_room, inj_err, tx_nchar, exp_seq, last_cnt, have_last} = '0;
    {mismatches, total_checks} = '0;
    rx_sync_ready = 1'b1;
    prev_end = 1'b1;
    lfsr_state = 16'he371;
    reset = 1'b1;
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (16) send_nchars(4'h0);
    $display("test nchars done");
    for (int i = 0; i < 12; i++) send_credit(8'(i % 10), rnd(), 1'b0);
    send_credit(8'h07, 8'h80, 1'b0);
    send_credit(8'h08, 8'hff, 1'b0);
    send_credit(8'h02, 8'hff, 1'b0);
    frames(int'(rnd() & 8'h03) + 1);
    send_credit(8'h00, 8'hff, 1'b0);
    credit_req = 1'b1;
    credit_vc = 8'h03;
    buffer_room = 8'hff;
    frame_sent = 1'b1;
    step();
    cmp_val("held credit", 8'h00, {7'h0, credit_taken_reg});
    frame_sent = 1'b0;
    credit_req = 1'b0;
    exp_seq[6:0] = exp_seq[6:0] + 7'h1;
    step();
    frames(130);
    send_credit(8'h05, 8'hff, 1'b0);
    send_credit(8'h01, 8'hff, 1'b1);
    $display("test credits done");
    retry_start = 1'b1;
    step();
    retry_start = 1'b0;
    exp_seq[7] = ~exp_seq[7];
    step();
    cmp_val("retry seq", exp_seq, tx_seq_reg);
    flush = 1'b1;
    step();
    flush = 1'b0;
    exp_seq = 8'h00;
    have_last = 1'b0;
    step();
    cmp_val("flush seq", 8'h00, tx_seq_reg);
    send_credit(8'h04, 8'hff, 1'b0);
    $display("test sequence done");
    repeat (4) send_nchars(4'(rnd()) | 4'h1);
    bad_window(1'b1);
    bad_window(1'b0);
    $display("test receive errors done");
    close_out();
  end
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
endmodule : fenc_codec_tb_top

bind fenc_codec fenc_codec_properties u_props (.*);
